// file: hw/tap_scan_defs.svh
`ifndef TAP_SCAN_DEFS_SVH
`define TAP_SCAN_DEFS_SVH

`define IR_WIDTH 8
`define IR_CAPTURE 8'h81
`define IR_BYPASS 8'hFF
`define IR_RESET 8'hFF
`define BYP_CAPTURE 1'h0
`define DR_WIDTH 8
`define DR_RESET 8'h00

`endif

// file: hw/tap_pkg.sv
package tap_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_e;

endpackage

// file: hw/sync_2ff.sv
`timescale 1ns/10ps
`default_nettype none

module sync_2ff (
    input wire logic clk, // Destination clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic d, // Level from another domain.
    output logic q // Synchronised level.
);

    logic meta;
    logic next_meta;
    logic next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'h0;
            q <= 1'h0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end

endmodule

`default_nettype wire

// file: hw/tap_fsm.sv
`timescale 1ns/10ps
`default_nettype none

module tap_fsm import tap_pkg::*; (
    input wire logic tck, // Test clock.
    input wire logic rst_b, // Reset in the test clock domain, active low.
    input wire logic tms, // Mode select, sampled on rising edges.
    output var tap_state_e state // Present controller state.
);

    tap_state_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            TEST_LOGIC_RESET: next_state = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: next_state = tms ? SELECT_IR : CAPTURE_DR; // R10
            CAPTURE_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: next_state = tms ? TEST_LOGIC_RESET : CAPTURE_IR; // R10
            CAPTURE_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: next_state = tms ? SELECT_DR : RUN_TEST_IDLE;
            default: next_state = TEST_LOGIC_RESET;
        endcase
    end

    // State moves on rising edges only.
    always_ff @(posedge tck or negedge rst_b) begin // R7
        if (!rst_b) begin
            state <= TEST_LOGIC_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule

`default_nettype wire

// file: hw/jtag_tap_bypass_scan.sv
// How it works
// R1: Capture-DR loads zero into bypass stage.
// R2: TDO driven from falling edge in Shift-DR.
// R3: Shift one TDI bit each rising edge.
// R4: Bypass delays TDI to TDO one stage.
// R5: Exit1-DR falling edge tri-states TDO.
// R6: Update-DR moves shifted data to parallel stage.
// R7: Sample on rising, change TDO on falling.
// R8: Eight-bit IR captures 10000001 in Capture-IR.
// R9: All-ones instruction selects the bypass register.
// R10: TMS high walks Select-DR, Select-IR, reset.
`timescale 1ns/10ps
`default_nettype none
`include "tap_scan_defs.svh"

module jtag_tap_bypass_scan import tap_pkg::*; (
    input wire logic sys_clk, // System clock, 10 MHz.
    input wire logic rst_b, // Reset, active low, asynchronous.
    input wire logic tck, // Test clock from the controller.
    input wire logic tms, // Test mode select.
    input wire logic tdi, // Serial test data in.
    output logic tdo, // Serial test data out.
    output logic tdo_oe, // High while tdo is driven.
    output logic bypass_active, // Bypass is the selected data register.
    output logic test_done, // Controller rests in Test-Logic-Reset.
    output logic [`DR_WIDTH-1:0] data_word, // Last updated scan word.
    output logic data_strobe // One-cycle pulse with a new data_word.
);

    // Reset release in both domains.
    logic rst_sys_b;
    logic rst_tck_b;

    sync_2ff u_rst_sys (
        .clk(sys_clk),
        .rst_b(rst_b),
        .d(1'h1),
        .q(rst_sys_b)
    );

    // The test clock may stop between scans, so its reset releases on its own edges.
    sync_2ff u_rst_tck (
        .clk(tck),
        .rst_b(rst_b),
        .d(1'h1),
        .q(rst_tck_b)
    );

    tap_state_e state;

    tap_fsm u_fsm (
        .tck(tck),
        .rst_b(rst_tck_b),
        .tms(tms),
        .state(state)
    );

    // Rising-edge shift stages.
    logic [`IR_WIDTH-1:0] ir_shift;
    logic [`IR_WIDTH-1:0] next_ir_shift;
    logic byp;
    logic next_byp;
    logic [`DR_WIDTH-1:0] dr_shift;
    logic [`DR_WIDTH-1:0] next_dr_shift;

    // Falling-edge stages.
    logic [`IR_WIDTH-1:0] ir;
    logic [`IR_WIDTH-1:0] next_ir;
    logic [`DR_WIDTH-1:0] dr_shadow;
    logic [`DR_WIDTH-1:0] next_dr_shadow;
    logic next_tdo;
    logic next_tdo_oe;
    logic upd_tog;
    logic next_upd_tog;
    logic idle_flag;
    logic next_idle_flag;

    // Kept in a flip-flop so that the crossing to sys_clk never sees a decode glitch.
    logic bypass_sel;
    logic next_bypass_sel;

    always_comb begin
        next_ir_shift = ir_shift;
        next_byp = byp;
        next_dr_shift = dr_shift;
        case (state)
            CAPTURE_IR: begin
                next_ir_shift = `IR_CAPTURE; // R8
            end
            SHIFT_IR: begin
                next_ir_shift = {tdi, ir_shift[`IR_WIDTH-1:1]}; // R3
            end
            CAPTURE_DR: begin
                if (bypass_sel) begin
                    next_byp = `BYP_CAPTURE; // R1
                end else begin
                    next_dr_shift = dr_shadow;
                end
            end
            SHIFT_DR: begin
                if (bypass_sel) begin
                    next_byp = tdi; // R3 R4
                end else begin
                    next_dr_shift = {tdi, dr_shift[`DR_WIDTH-1:1]}; // R3
                end
            end
            default: begin
                next_byp = byp;
            end
        endcase
    end

    // TDI is sampled on the rising edge, after the controller changed it on the falling one.
    always_ff @(posedge tck or negedge rst_tck_b) begin // R7
        if (!rst_tck_b) begin
            ir_shift <= `IR_CAPTURE;
            byp <= `BYP_CAPTURE;
            dr_shift <= `DR_RESET;
        end else begin
            ir_shift <= next_ir_shift;
            byp <= next_byp;
            dr_shift <= next_dr_shift;
        end
    end

    always_comb begin
        next_ir = ir;
        next_dr_shadow = dr_shadow;
        next_tdo = tdo;
        next_tdo_oe = 1'h0; // R5
        next_upd_tog = upd_tog;
        next_idle_flag = (state == TEST_LOGIC_RESET);
        case (state)
            TEST_LOGIC_RESET: begin
                next_ir = `IR_RESET;
            end
            SHIFT_IR: begin
                next_tdo = ir_shift[0];
                next_tdo_oe = 1'h1;
            end
            SHIFT_DR: begin
                next_tdo = bypass_sel ? byp : dr_shift[0]; // R4
                next_tdo_oe = 1'h1; // R2
            end
            UPDATE_IR: begin
                next_ir = ir_shift; // R9
            end
            UPDATE_DR: begin
                if (!bypass_sel) begin
                    next_dr_shadow = dr_shift; // R6
                    next_upd_tog = ~upd_tog;
                end
            end
            default: begin
                next_tdo = tdo;
            end
        endcase
        next_bypass_sel = (next_ir == `IR_BYPASS); // R9
    end

    // Outputs and update stages change on the falling edge, half a cycle clear of sampling.
    always_ff @(negedge tck or negedge rst_tck_b) begin // R7
        if (!rst_tck_b) begin
            ir <= `IR_RESET;
            dr_shadow <= `DR_RESET;
            tdo <= 1'h0;
            tdo_oe <= 1'h0;
            upd_tog <= 1'h0;
            idle_flag <= 1'h1;
            bypass_sel <= (`IR_RESET == `IR_BYPASS);
        end else begin
            ir <= next_ir;
            dr_shadow <= next_dr_shadow;
            tdo <= next_tdo;
            tdo_oe <= next_tdo_oe;
            upd_tog <= next_upd_tog;
            idle_flag <= next_idle_flag;
            bypass_sel <= next_bypass_sel;
        end
    end

    // System side. The update toggle crosses through two flip-flops; the word itself
    // is held still in dr_shadow until the next Update-DR, at least four test clocks away.
    logic upd_sync;
    logic upd_seen;
    logic next_upd_seen;
    logic byp_sync;
    logic idle_sync;
    logic [`DR_WIDTH-1:0] next_data_word;
    logic next_data_strobe;
    logic next_bypass_active;
    logic next_test_done;

    sync_2ff u_upd_sync (
        .clk(sys_clk),
        .rst_b(rst_sys_b),
        .d(upd_tog),
        .q(upd_sync)
    );

    sync_2ff u_byp_sync (
        .clk(sys_clk),
        .rst_b(rst_sys_b),
        .d(bypass_sel),
        .q(byp_sync)
    );

    sync_2ff u_idle_sync (
        .clk(sys_clk),
        .rst_b(rst_sys_b),
        .d(idle_flag),
        .q(idle_sync)
    );

    always_comb begin
        next_upd_seen = upd_sync;
        next_data_strobe = (upd_sync != upd_seen);
        next_data_word = (upd_sync != upd_seen) ? dr_shadow : data_word;
        next_bypass_active = byp_sync;
        next_test_done = idle_sync;
    end

    always_ff @(posedge sys_clk or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            upd_seen <= 1'h0;
            data_strobe <= 1'h0;
            data_word <= `DR_RESET;
            bypass_active <= 1'h0;
            test_done <= 1'h0;
        end else begin
            upd_seen <= next_upd_seen;
            data_strobe <= next_data_strobe;
            data_word <= next_data_word;
            bypass_active <= next_bypass_active;
            test_done <= next_test_done;
        end
    end

    // Checks in the test clock domain, except chk_strobe_pulse on sys_clk.
    chk_byp_capture: assert property (@(posedge tck) disable iff (!rst_tck_b) // R1
        (state == CAPTURE_DR) && bypass_sel |=> (byp == 1'h0))
        else $error("bypass stage did not capture zero");

    chk_tdo_enable: assert property (@(posedge tck) disable iff (!rst_tck_b) // R2
        (state == SHIFT_DR) |-> tdo_oe)
        else $error("tdo not driven during Shift-DR");

    chk_shift_in: assert property (@(posedge tck) disable iff (!rst_tck_b) // R3
        (state == SHIFT_DR) && bypass_sel |=> (byp == $past(tdi)))
        else $error("bypass stage missed a tdi bit");

    chk_byp_delay: assert property (@(posedge tck) disable iff (!rst_tck_b) // R4
        (state == SHIFT_DR) && bypass_sel ##1 (state == SHIFT_DR) |-> (tdo == $past(tdi)))
        else $error("tdo is not tdi delayed one stage");

    chk_tdo_release: assert property (@(posedge tck) disable iff (!rst_tck_b) // R5
        (state == EXIT1_DR) |-> !tdo_oe)
        else $error("tdo still driven after Exit1-DR");

    chk_dr_update: assert property (@(posedge tck) disable iff (!rst_tck_b) // R6
        (state == UPDATE_DR) && !bypass_sel |=> (dr_shadow == $past(dr_shift)))
        else $error("parallel stage not updated in Update-DR");

    chk_ir_capture: assert property (@(posedge tck) disable iff (!rst_tck_b) // R8
        (state == CAPTURE_IR) |=> (ir_shift == `IR_CAPTURE))
        else $error("instruction register capture value wrong");

    chk_bypass_select: assert property (@(posedge tck) disable iff (!rst_tck_b) // R9
        (state == UPDATE_IR) && (ir_shift == `IR_BYPASS) |=> bypass_sel)
        else $error("all-ones instruction did not select bypass");

    chk_exit_path: assert property (@(posedge tck) disable iff (!rst_tck_b) // R10
        (state == SELECT_DR) && tms ##1 tms |=> (state == TEST_LOGIC_RESET))
        else $error("TMS high did not return to Test-Logic-Reset");

    chk_dr_shift_in: assert property (@(posedge tck) disable iff (!rst_tck_b) // R3
        (state == SHIFT_DR) && !bypass_sel |=> (dr_shift[`DR_WIDTH-1] == $past(tdi)))
        else $error("scan register missed a tdi bit");

    chk_reset_bypass: assert property (@(posedge tck) disable iff (!rst_tck_b) // R9
        (state == TEST_LOGIC_RESET) |-> bypass_sel)
        else $error("bypass not selected in Test-Logic-Reset");

    chk_strobe_pulse: assert property (@(posedge sys_clk) disable iff (!rst_sys_b) // R6
        data_strobe |=> !data_strobe)
        else $error("data_strobe longer than one cycle");

    cov_user_scan: cover property (@(posedge tck) disable iff (!rst_tck_b)
        (state == SHIFT_DR) && !bypass_sel ##1 (state == EXIT1_DR));

    cov_bypass_scan: cover property (@(posedge tck) disable iff (!rst_tck_b)
        (state == SHIFT_DR) && bypass_sel ##1 (state == EXIT1_DR) ##1 (state == UPDATE_DR));

    cov_ir_bypass: cover property (@(posedge tck) disable iff (!rst_tck_b)
        (state == UPDATE_IR) && (ir_shift == `IR_BYPASS));

    cov_return_reset: cover property (@(posedge tck) disable iff (!rst_tck_b)
        (state == SELECT_DR) ##1 (state == SELECT_IR) ##1 (state == TEST_LOGIC_RESET));

    cov_word_strobe: cover property (@(posedge sys_clk) disable iff (!rst_sys_b)
        data_strobe);

endmodule

`default_nettype wire

// file: dv/jtag_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module jtag_ctrl_model (
    output logic tck, // Test clock, runs only within frames.
    output logic tms, // Mode select to the device.
    output logic tdi // Serial data to the device.
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Each bit is set while tck is low, so it is settled well before the rising edge.
    task automatic frame(input logic [31:0] tms_v, input logic [31:0] tdi_v, input int n);
        for (int i = 0; i < n; i++) begin
            tms = tms_v[i];
            tdi = tdi_v[i];
            #32 tck = 1'b1;
            #32 tck = 1'b0;
        end
        // Once the frame is over the data line must not look like a held bit.
        tdi = ~tdi;
    endtask
endmodule

`default_nettype wire

// file: dv/jtag_tap_bypass_scan_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tap_scan_defs.svh"

module jtag_tap_bypass_scan_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    wire tck;
    wire tms;
    wire tdi;
    logic tdo;
    logic tdo_oe;
    logic bypass_active;
    logic tlr_flag;
    logic [7:0] data_word;
    logic data_strobe;
    wire tdo_pin = tdo_oe ? tdo : 1'bz;
    int failures = 0;
    int checks_done = 0;
    integer seed = 59038;
    logic [7:0] prev_word = `DR_RESET;
    logic [7:0] ir;
    logic [7:0] dr;
    logic tdo_q[$];
    logic [7:0] word_q[$];

    jtag_ctrl_model jtag_ctrl_model_i (.tck(tck), .tms(tms), .tdi(tdi));

    jtag_tap_bypass_scan jtag_tap_bypass_scan_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .bypass_active(bypass_active),
        .test_done(tlr_flag), .data_word(data_word), .data_strobe(data_strobe));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One IR scan, one DR scan of nd bits, then TMS high back to Test-Logic-Reset.
    task automatic scan(input logic [7:0] ir_v, input logic [7:0] dr_v, input int nd,
                        input logic [7:0] exp_dr);
        logic [31:0] tv;
        logic [31:0] dv;
        logic [7:0] cap;
        int p;
        tv = 32'h0;
        dv = 32'h0;
        cap = `IR_CAPTURE;
        p = 16 + nd;
        tv[2:1] = 2'b11;
        tv[14:12] = 3'b111;
        tv[p +: 5] = 5'h1F;
        for (int i = 0; i < 8; i++) begin
            dv[5 + i] = ir_v[i];
            tdo_q.push_back(cap[i]);
        end
        for (int i = 0; i < nd; i++) begin
            dv[17 + i] = dr_v[i];
            tdo_q.push_back(exp_dr[i]);
        end
        jtag_ctrl_model_i.frame(tv, dv, p + 5);
        repeat (20) @(negedge sys_clk);
        check("tdo_oe idle", {7'h00, tdo_oe}, 8'h00);
        check("tdo bits left", 8'(tdo_q.size()), 8'h00);
        check("updates left", 8'(word_q.size()), 8'h00);
        check("test_done", {7'h00, tlr_flag}, 8'h01);
    endtask

    // A shifted bit is judged at the rising edge, where the controller samples it.
    always @(posedge tck) begin
        if (tdo_oe === 1'b1) begin
            if (tdo_q.size() == 0)
                check("tdo enable", 8'h01, 8'h00);
            else
                check("tdo", {7'h00, tdo_pin}, {7'h00, tdo_q.pop_front()});
        end
    end

    // Judged at the falling edge, half a cycle clear of the edge that launches the outputs.
    always @(negedge sys_clk) begin
        if (data_strobe === 1'b1) begin
            if (word_q.size() == 0)
                check("data_strobe", 8'h01, 8'h00);
            else
                check("data_word", data_word, word_q.pop_front());
            // The scan instruction is still in place when its word arrives.
            check("bypass_active at update", {7'h00, bypass_active}, 8'h00);
        end
    end

    initial begin
        #100000;
        failures++;
        test_done;
    end

    initial begin
        // The link clock must run during reset so the tck side can leave it.
        fork
            jtag_ctrl_model_i.frame(32'hFFFFFFFF, 32'h0, 12);
            begin
                repeat (4) @(negedge sys_clk);
                rst_b <= 1'b1;
            end
        join
        repeat (4) @(negedge sys_clk);
        check("test_done", {7'h00, tlr_flag}, 8'h01);
        check("bypass_active", {7'h00, bypass_active}, 8'h01);
        // Pattern 101 through the one-stage path comes out as 010, captured zero first.
        scan(`IR_BYPASS, 8'h05, 3, 8'h02);
        check("bypass_active", {7'h00, bypass_active}, 8'h01);
        for (int r = 0; r < 2; r++) begin
            ir = 8'($random(seed)) & 8'h7F;
            dr = 8'($random(seed));
            word_q.push_back(dr);
            scan(ir, dr, 8, prev_word);
            prev_word = dr;
            // Test-Logic-Reset at the end of the scan restores the bypass instruction.
            check("bypass_active", {7'h00, bypass_active}, 8'h01);
        end
        scan(`IR_BYPASS, 8'h05, 3, 8'h02);
        check("bypass_active", {7'h00, bypass_active}, 8'h01);
        test_done;
    end
endmodule

`default_nettype wire
